// File: inc/plc_consts.svh
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

`define PLC_ADDR_TUNE 16'h8004
`define PLC_ADDR_IDVER 16'hca00
`define PLC_ADDR_CTRL0 16'hca01
`define PLC_ADDR_CTRL1 16'hca02

`define PLC_PRE_MSB 13
`define PLC_PRE_LSB 8
`define PLC_COMMIT_MSB 5
`define PLC_COMMIT_LSB 0
`define PLC_HI_MSB 15
`define PLC_HI_LSB 8
`define PLC_LO_MSB 7
`define PLC_LO_LSB 0
`define PLC_ENABLE_BIT 15
`define PLC_RESET_BIT 14

`define PLC_PRE_RESET 6'h35
`define PLC_COMMIT_RESET 6'h20
`define PLC_LAYOUT_ID 8'h0a
`define PLC_LAYOUT_VER 8'h10
`define PLC_COUNT_RESET 8'h08
`define PLC_NODE_RESET 8'hff
`define PLC_NODE_COORD 8'h00

`define PLC_CLK_NS 50
`define PLC_SUBRESET_NS 200

`endif

// File: inc/plc_pkg.sv
package plc_pkg;
	typedef logic [15:0] plc_word_t;
	typedef logic [5:0] plc_thr_t;
	typedef logic [7:0] plc_byte_t;
	typedef enum logic {
		PLC_SEQ_IDLE,
		PLC_SEQ_PULSE
	} plc_seq_state_t;
endpackage

// File: core/plc_reset_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"
module plc_reset_seq (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic start_in,
	output logic busy_out
);
	localparam int PULSE_CYCLES =
		(`PLC_SUBRESET_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS;
	localparam logic [3:0] LAST_COUNT = 4'(PULSE_CYCLES - 1);

	plc_pkg::plc_seq_state_t state;
	logic [3:0] count;

	// Reset pulse length; a new start during the pulse restarts it
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= plc_pkg::PLC_SEQ_IDLE;
			count <= 4'h0;
		end else begin
			case (state)
				plc_pkg::PLC_SEQ_IDLE: begin
					if (start_in) begin
						state <= plc_pkg::PLC_SEQ_PULSE;
						count <= LAST_COUNT;
					end
				end
				plc_pkg::PLC_SEQ_PULSE: begin
					if (start_in) begin
						count <= LAST_COUNT;
					end else if (count == 4'h0) begin
						state <= plc_pkg::PLC_SEQ_IDLE;
					end else begin
						count <= count - 4'h1;
					end
				end
				default: begin
					state <= plc_pkg::PLC_SEQ_IDLE;
				end
			endcase
		end
	end

	assign busy_out = (state == plc_pkg::PLC_SEQ_PULSE);
endmodule // plc_reset_seq
`default_nettype wire

// File: core/plc_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"
module plc_config_regs (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic coord_override_in,
	input wire logic coord_role_in,
	input wire logic enhanced_noise_immunity_in,
	input wire logic [5:0] preamble_score_in,
	input wire logic [5:0] commit_score_in,
	output logic preamble_detect_out,
	output logic commit_detect_out,
	output logic [5:0] preamble_threshold_out,
	output logic [5:0] commit_threshold_out,
	output logic ca_active_out,
	output logic coordinator_out,
	output logic [7:0] opportunity_count_out,
	output logic sublayer_reset_out
);
	default clocking plc_cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	// Address match, shared by write and read decoding
	function automatic logic addr_hit(input logic [15:0] addr,
		input logic [15:0] target);
		addr_hit = (addr == target);
	endfunction

	plc_pkg::plc_thr_t preamble_thr;
	plc_pkg::plc_thr_t commit_thr;
	logic ca_enable;
	plc_pkg::plc_byte_t node_count;
	plc_pkg::plc_byte_t node_id;
	logic reset_start;
	logic reset_busy;
	logic next_active;
	logic next_coord;
	plc_pkg::plc_thr_t thr_sel [2];
	plc_pkg::plc_thr_t thr_def [2];
	plc_pkg::plc_thr_t score [2];
	logic detect [2];

	// Tuning thresholds
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			preamble_thr <= `PLC_PRE_RESET;
			commit_thr <= `PLC_COMMIT_RESET;
		end else if (reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_TUNE)) begin
			preamble_thr <= reg_wdata_in[`PLC_PRE_MSB:`PLC_PRE_LSB];
			commit_thr <= reg_wdata_in[`PLC_COMMIT_MSB:`PLC_COMMIT_LSB];
		end
	end

	// Control 0: enable; reset bit only starts the sequencer
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ca_enable <= 1'b0;
		end else if (reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)) begin
			ca_enable <= reg_wdata_in[`PLC_ENABLE_BIT];
		end
	end

	assign reset_start = reg_wr_in
		&& addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)
		&& reg_wdata_in[`PLC_RESET_BIT];

	// Control 1: node count and local node id
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			node_count <= `PLC_COUNT_RESET;
			node_id <= `PLC_NODE_RESET;
		end else if (reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL1)) begin
			node_count <= reg_wdata_in[`PLC_HI_MSB:`PLC_HI_LSB];
			node_id <= reg_wdata_in[`PLC_LO_MSB:`PLC_LO_LSB];
		end
	end

	plc_reset_seq u_reset_seq (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.start_in(reset_start),
		.busy_out(reset_busy)
	);

	// Sublayer reset output; touches no configuration register
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sublayer_reset_out <= 1'b0;
		end else begin
			sublayer_reset_out <= reset_busy || reset_start;
		end
	end

	// Role and activity
	always_comb begin
		next_active = ca_enable && (node_id != `PLC_NODE_RESET);
		if (coord_override_in) begin
			next_coord = coord_role_in;
		end else begin
			next_coord = (node_id == `PLC_NODE_COORD);
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ca_active_out <= 1'b0;
			coordinator_out <= 1'b0;
			opportunity_count_out <= 8'h00;
		end else begin
			ca_active_out <= next_active;
			coordinator_out <= next_active && next_coord;
			if (next_active && next_coord) begin
				opportunity_count_out <= node_count;
			end else begin
				opportunity_count_out <= 8'h00;
			end
		end
	end

	// Threshold outputs and detectors; defaults apply while immunity is off
	assign thr_def[0] = `PLC_PRE_RESET;
	assign thr_def[1] = `PLC_COMMIT_RESET;
	assign score[0] = preamble_score_in;
	assign score[1] = commit_score_in;
	assign thr_sel[0] = enhanced_noise_immunity_in ? preamble_thr : thr_def[0];
	assign thr_sel[1] = enhanced_noise_immunity_in ? commit_thr : thr_def[1];

	generate
		for (genvar i = 0; i < 2; i++) begin : g_det
			always_ff @(posedge mclk_in or posedge reset_in) begin
				if (reset_in) begin
					detect[i] <= 1'b0;
				end else begin
					detect[i] <= (score[i] >= thr_sel[i]);
				end
			end
		end
	endgenerate

	assign preamble_detect_out = detect[0];
	assign commit_detect_out = detect[1];

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			preamble_threshold_out <= `PLC_PRE_RESET;
			commit_threshold_out <= `PLC_COMMIT_RESET;
		end else begin
			preamble_threshold_out <= thr_sel[0];
			commit_threshold_out <= thr_sel[1];
		end
	end

	// Read path; unmapped addresses and unused bits read zero
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (!reg_rd_in) begin
				reg_rdata_out <= 16'h0000;
			end else if (addr_hit(reg_addr_in, `PLC_ADDR_TUNE)) begin
				reg_rdata_out <= {2'b00, preamble_thr, 2'b00, commit_thr};
			end else if (addr_hit(reg_addr_in, `PLC_ADDR_IDVER)) begin
				reg_rdata_out <= {`PLC_LAYOUT_ID, `PLC_LAYOUT_VER};
			end else if (addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)) begin
				reg_rdata_out <= {ca_enable, reset_busy, 14'h0000};
			end else if (addr_hit(reg_addr_in, `PLC_ADDR_CTRL1)) begin
				reg_rdata_out <= {node_count, node_id};
			end else begin
				reg_rdata_out <= 16'h0000;
			end
		end
	end

	// Checks
	id_readback_a: assert property (
		reg_rd_in && addr_hit(reg_addr_in, `PLC_ADDR_IDVER)
		|=> reg_rvalid_out && reg_rdata_out == 16'h0a10)
		else $error("identification readback wrong");

	tune_pad_zero_a: assert property (
		reg_rd_in && addr_hit(reg_addr_in, `PLC_ADDR_TUNE)
		|=> reg_rdata_out[15:14] == 2'b00 && reg_rdata_out[7:6] == 2'b00)
		else $error("unused tune bits not zero");

	tune_write_a: assert property (
		reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_TUNE)
		##1 enhanced_noise_immunity_in [*2]
		|-> preamble_threshold_out == $past(reg_wdata_in[13:8], 2)
		&& commit_threshold_out == $past(reg_wdata_in[5:0], 2))
		else $error("tune write not applied");

	detect_order_a: assert property (
		##1 preamble_detect_out
		== ($past(preamble_score_in) >= $past(thr_sel[0])))
		else $error("preamble detector compare wrong");

	commit_order_a: assert property (
		##1 commit_detect_out
		== ($past(commit_score_in) >= $past(thr_sel[1])))
		else $error("commit detector compare wrong");

	thr_default_a: assert property (
		!enhanced_noise_immunity_in
		|=> preamble_threshold_out == `PLC_PRE_RESET
		&& commit_threshold_out == `PLC_COMMIT_RESET)
		else $error("default thresholds not used");

	thr_follow_a: assert property (
		enhanced_noise_immunity_in
		|=> preamble_threshold_out == $past(preamble_thr)
		&& commit_threshold_out == $past(commit_thr))
		else $error("programmed thresholds not used");

	tune_keep_a: assert property (
		!(reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_TUNE))
		|=> $stable(preamble_thr) && $stable(commit_thr))
		else $error("thresholds changed without a write");

	unmapped_read_a: assert property (
		reg_rd_in && !addr_hit(reg_addr_in, `PLC_ADDR_TUNE)
		&& !addr_hit(reg_addr_in, `PLC_ADDR_IDVER)
		&& !addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)
		&& !addr_hit(reg_addr_in, `PLC_ADDR_CTRL1)
		|=> reg_rvalid_out && reg_rdata_out == 16'h0000)
		else $error("unmapped read not zero");

	ctrl0_read_a: assert property (
		reg_rd_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)
		|=> reg_rdata_out[13:0] == 14'h0000
		&& reg_rdata_out[14] == $past(reset_busy)
		&& reg_rdata_out[15] == $past(ca_enable))
		else $error("control 0 readback wrong");

	ctrl1_read_a: assert property (
		reg_rd_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL1)
		|=> reg_rdata_out == {$past(node_count), $past(node_id)})
		else $error("control 1 readback wrong");

	ctrl1_write_a: assert property (
		reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL1)
		|=> node_count == $past(reg_wdata_in[15:8])
		&& node_id == $past(reg_wdata_in[7:0]))
		else $error("control 1 write not applied");

	start_pulse_a: assert property (
		reset_start |=> sublayer_reset_out && reset_busy)
		else $error("sublayer reset did not start");

	pulse_width_a: assert property (
		reset_start |=> sublayer_reset_out [*5])
		else $error("sublayer reset pulse cut short");

	reset_len_a: assert property (
		$fell(sublayer_reset_out) |-> $past(sublayer_reset_out, 4))
		else $error("sublayer reset pulse too short");

	reset_clear_a: assert property (
		reset_start ##1 (!reset_start) [*6]
		|-> !reset_busy)
		else $error("reset bit did not clear");

	reset_keep_a: assert property (
		reset_busy && !reg_wr_in |=> $stable(node_id) && $stable(node_count)
		&& $stable(ca_enable) && $stable(preamble_thr))
		else $error("configuration changed by sublayer reset");

	idle_off_a: assert property (
		node_id == 8'hff |=> !ca_active_out && !coordinator_out)
		else $error("function active with node id 0xFF");

	enable_off_a: assert property (
		!ca_enable |=> !ca_active_out && !coordinator_out
		&& opportunity_count_out == 8'h00)
		else $error("function active while disabled");

	count_gate_a: assert property (
		!(next_active && next_coord) |=> opportunity_count_out == 8'h00)
		else $error("count leaked outside coordinator role");

	coord_count_a: assert property (
		ca_enable && node_id == `PLC_NODE_COORD && !coord_override_in
		|=> opportunity_count_out == $past(node_count))
		else $error("coordinator count not applied");

	id_zero_role_a: assert property (
		ca_enable && node_id == 8'h00 && !coord_override_in
		|=> coordinator_out)
		else $error("node id zero not coordinator");

	follower_role_a: assert property (
		ca_enable && node_id != `PLC_NODE_COORD
		&& node_id != `PLC_NODE_RESET && !coord_override_in
		|=> ca_active_out && !coordinator_out)
		else $error("follower took coordinator role");

	override_role_a: assert property (
		next_active && coord_override_in
		|=> coordinator_out == $past(coord_role_in))
		else $error("override role not followed");

	enable_write_a: assert property (
		reg_wr_in && addr_hit(reg_addr_in, `PLC_ADDR_CTRL0)
		|=> ca_enable == $past(reg_wdata_in[15]))
		else $error("enable bit not written");
endmodule // plc_config_regs
`default_nettype wire

// File: bench/plc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module plc_host_model (
	input wire logic mclk_in,
	input wire logic [15:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	output logic [15:0] reg_addr_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [15:0] reg_wdata_out
);
	initial begin
		reg_addr_out = 16'h0000;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_wdata_out = 16'h0000;
	end

	// Node id kept within node count by the caller
	task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk_in) #1;
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(posedge mclk_in) #1;
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask

	task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge mclk_in) #1;
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(posedge mclk_in) #1;
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
		d = 16'hxxxx;
		if (reg_rvalid_in === 1'b1)
			d = reg_rdata_in;
	endtask
endmodule // plc_host_model
`default_nettype wire

// File: bench/plc_config_rx_tune_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "plc_consts.svh"
module plc_config_rx_tune_regs_tb;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic ovr = 1'b0;
	logic role = 1'b0;
	logic noise_imm = 1'b0;
	logic [5:0] pre_sc = 6'h00;
	logic [5:0] com_sc = 6'h00;
	logic [15:0] addr, wdata, rdata;
	logic wr, rd, rvalid, pre_det, com_det, ca, coord, sub_rst;
	logic [5:0] pre_thr, com_thr;
	logic [7:0] opp;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	plc_pkg::plc_word_t rd_val;

	always #25 mclk_in = ~mclk_in;

	plc_host_model u_host (.mclk_in(mclk_in), .reg_rdata_in(rdata),
		.reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_wr_out(wr),
		.reg_rd_out(rd), .reg_wdata_out(wdata));

	plc_config_regs u_dut (.mclk_in(mclk_in), .reset_in(reset_in),
		.reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.coord_override_in(ovr), .coord_role_in(role),
		.enhanced_noise_immunity_in(noise_imm), .preamble_score_in(pre_sc),
		.commit_score_in(com_sc), .preamble_detect_out(pre_det),
		.commit_detect_out(com_det), .preamble_threshold_out(pre_thr),
		.commit_threshold_out(com_thr), .ca_active_out(ca),
		.coordinator_out(coord), .opportunity_count_out(opp),
		.sublayer_reset_out(sub_rst));

	task automatic check(input plc_pkg::plc_word_t seen,
		input plc_pkg::plc_word_t exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		u_host.read_reg(a, rd_val);
		check(rd_val, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// Role outputs packed as active, coordinator, count
	task automatic role_chk(input logic [15:0] exp);
		idle(2);
		check({6'h00, ca, coord, opp}, exp);
	endtask

	// Receiver inputs applied, thresholds and detects compared
	task automatic rx_chk(input logic e, input logic [5:0] p,
		input logic [5:0] c, input logic [15:0] exp);
		noise_imm = e;
		pre_sc = p;
		com_sc = c;
		idle(3);
		check({2'b00, pre_thr, pre_det, com_thr, com_det}, exp);
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			stop_test;
		end
	end

	initial begin
		repeat (10) @(posedge mclk_in);
		#1 reset_in = 1'b0;
		rd_chk(`PLC_ADDR_TUNE, 16'h3520);
		rd_chk(`PLC_ADDR_IDVER, 16'h0a10);
		rd_chk(`PLC_ADDR_CTRL0, 16'h0000);
		rd_chk(`PLC_ADDR_CTRL1, 16'h08ff);
		role_chk(16'h0000);
		$display("test reset_values done");
		u_host.write_reg(`PLC_ADDR_TUNE, 16'hffff);
		rd_chk(`PLC_ADDR_TUNE, 16'h3f3f);
		u_host.write_reg(`PLC_ADDR_IDVER, 16'h0000);
		rd_chk(`PLC_ADDR_IDVER, 16'h0a10);
		u_host.write_reg(`PLC_ADDR_CTRL0, 16'h3fff);
		rd_chk(`PLC_ADDR_CTRL0, 16'h0000);
		u_host.write_reg(16'h1234, 16'hffff);
		rd_chk(16'h1234, 16'h0000);
		$display("test access_kinds done");
		rx_chk(1'b0, 6'h35, 6'h1f, 16'h35c0);
		rx_chk(1'b1, 6'h3e, 6'h3f, 16'h3f7f);
		u_host.write_reg(`PLC_ADDR_TUNE, 16'h0000);
		rx_chk(1'b1, 6'h00, 6'h00, 16'h0081);
		$display("test thresholds done");
		u_host.write_reg(`PLC_ADDR_CTRL1, 16'h0500);
		u_host.write_reg(`PLC_ADDR_CTRL0, 16'h8000);
		role_chk(16'h0305);
		u_host.write_reg(`PLC_ADDR_CTRL1, 16'h0502);
		role_chk(16'h0200);
		ovr = 1'b1;
		role = 1'b1;
		role_chk(16'h0305);
		role = 1'b0;
		u_host.write_reg(`PLC_ADDR_CTRL1, 16'h0500);
		role_chk(16'h0200);
		ovr = 1'b0;
		u_host.write_reg(`PLC_ADDR_CTRL1, 16'hffff);
		role_chk(16'h0000);
		$display("test roles done");
		u_host.write_reg(`PLC_ADDR_CTRL1, 16'h0500);
		u_host.write_reg(`PLC_ADDR_CTRL0, 16'h4000);
		check({15'h0000, sub_rst}, 16'h0001);
		rd_chk(`PLC_ADDR_CTRL0, 16'h4000);
		idle(6);
		rd_chk(`PLC_ADDR_CTRL0, 16'h0000);
		check({15'h0000, sub_rst}, 16'h0000);
		rd_chk(`PLC_ADDR_CTRL1, 16'h0500);
		rd_chk(`PLC_ADDR_TUNE, 16'h0000);
		role_chk(16'h0000);
		$display("test sublayer_reset done");
		stop_test;
	end
endmodule // plc_config_rx_tune_regs_tb
`default_nettype wire
